//--- isp_dev.sv
/*
 Device end: I2C slave giving byte access to the register map, with watchdog.
 Assumes SCL and SDA arrive synchronous to clk_in and a pull-up on both lines.
*/
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "isp_cfg.svh"
// Summary of operation
// - Answer 0x68, or 0x69 with select high
// - Seven-bit addressing only, standard and fast
// - Accept SCL up to 1 MHz
// - Start marks the bus busy
// - Stop ends the transaction
// - Receiver pulls SDA low for acknowledge
// - Stop straight after start is ignored
// - Write: address, register, data, stop
// - Read: register write, repeated start, read
// - Master ack continues, nack releases SDA
// - Address increments after each sent byte
// - Reads start at last written address
// - Watchdog frees a locked bus when enabled
// - Watchdog period 1 ms or 50 ms
// - Host idles 2 or 450 us after every transfer
// - I2C after reset, SPI on select edge
module isp_dev #(
    parameter int WDT_SHORT_CYC = `ISP_WDT_SHORT_MS * 1000000 / `ISP_CLK_NS,
    parameter int WDT_LONG_CYC = `ISP_WDT_LONG_MS * 1000000 / `ISP_CLK_NS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    isp_if.dev bus_if,
    input wire logic addr_select_pin_in,
    input wire logic chip_select_pin_in,
    output logic reg_wr_out,
    output logic [7:0] reg_wr_addr_out,
    output logic [7:0] reg_wr_data_out,
    output logic spi_mode_out,
    output logic busy_out,
    output logic wdt_reset_out
);
    import isp_pkg::*;

    if (WDT_SHORT_CYC < 1 || WDT_LONG_CYC < WDT_SHORT_CYC || WDT_LONG_CYC >= (1 << 24)) begin : g_chk
        $error("isp_dev: watchdog counts out of range");
    end

    isp_dev_st_t st_q;
    isp_phase_t ph_q;
    logic scl_q, sda_q, low_seen_q, read_q, sda_oe_q, cs_q, spi_q, wdt_fire_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, base_q, ptr_q, nonvolatile_interface_config_q;
    logic [23:0] wdt_cnt_q;
    logic [7:0] mem [0:(1 << `ISP_MEM_TOP_BIT) - 1];
    logic scl_rise, scl_fall, start_det, stop_det, abort, byte_done, mem_we;
    logic [23:0] wdt_limit;
    logic [7:0] rd_now;

    // Unmapped addresses above the array read as zero
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        if (a == `ISP_NONVOLATILE_INTERFACE_CONFIG_OFF) begin
            return nonvolatile_interface_config_q;
        end else if (a[`ISP_MEM_TOP_BIT]) begin
            return 8'h00;
        end else begin
            return mem[a[`ISP_MEM_TOP_BIT-1:0]];
        end
    endfunction : rd_byte

    // Byte the pointer names, ready for the next load
    always_comb begin
        rd_now = rd_byte(ptr_q);
    end

    assign scl_rise = bus_if.scl & ~scl_q;
    assign scl_fall = ~bus_if.scl & scl_q;
    assign start_det = scl_q & bus_if.scl & sda_q & ~bus_if.sda;
    // A stop needs an SCL low since the start
    assign stop_det = scl_q & bus_if.scl & ~sda_q & bus_if.sda & low_seen_q;
    assign abort = wdt_fire_q | spi_q | start_det | stop_det;
    assign byte_done = (st_q == DS_RX) && scl_fall && (bit_cnt_q == `ISP_BYTE_BITS);
    assign mem_we = byte_done && (ph_q == PH_DATA) && !abort;
    assign wdt_limit = nonvolatile_interface_config_q[`ISP_NV_WDT_SEL_BIT] ? 24'(WDT_LONG_CYC - 1)
                                                      : 24'(WDT_SHORT_CYC - 1);
    // Open drain: value stays low, only the enable moves
    assign bus_if.dev_sda_out = 1'b0;
    assign bus_if.dev_sda_oe = sda_oe_q;

    // Pins sampled once so edges stay clean at up to 1 MHz SCL
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus_if.scl;
            sda_q <= bus_if.sda;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_seen_q <= 1'b0;
            busy_out <= 1'b0;
        end else if (start_det) begin
            low_seen_q <= 1'b0;
            busy_out <= 1'b1;
        end else begin
            if (!bus_if.scl) begin
                low_seen_q <= 1'b1;
            end
            if (stop_det) begin
                busy_out <= 1'b0;
            end
        end
    end

    // Sticky until reset; a pin tied high never makes an edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_q <= 1'b1;
            spi_q <= 1'b0;
        end else begin
            cs_q <= chip_select_pin_in;
            if ((chip_select_pin_in & ~cs_q) | nonvolatile_interface_config_q[`ISP_NV_SPI_EN_BIT]) begin
                spi_q <= 1'b1;
            end
        end
    end
    assign spi_mode_out = spi_q;

    // Lockup means our own SDA pull stands with SCL frozen
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wdt_cnt_q <= 24'h000000;
            wdt_fire_q <= 1'b0;
        end else begin
            wdt_fire_q <= 1'b0;
            if (!nonvolatile_interface_config_q[`ISP_NV_WDT_EN_BIT] || !sda_oe_q || scl_rise || scl_fall) begin
                wdt_cnt_q <= 24'h000000;
            end else if (wdt_cnt_q >= wdt_limit) begin
                wdt_cnt_q <= 24'h000000;
                wdt_fire_q <= 1'b1;
            end else begin
                wdt_cnt_q <= wdt_cnt_q + 24'h000001;
            end
        end
    end
    assign wdt_reset_out = wdt_fire_q;

    always_ff @(posedge clk_in) begin
        if (mem_we && !ptr_q[`ISP_MEM_TOP_BIT]) begin
            mem[ptr_q[`ISP_MEM_TOP_BIT-1:0]] <= shift_q;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nonvolatile_interface_config_q <= `ISP_NONVOLATILE_INTERFACE_CONFIG_RST;
            reg_wr_out <= 1'b0;
            reg_wr_addr_out <= 8'h00;
            reg_wr_data_out <= 8'h00;
        end else begin
            reg_wr_out <= mem_we;
            if (mem_we) begin
                reg_wr_addr_out <= ptr_q;
                reg_wr_data_out <= shift_q;
                if (ptr_q == `ISP_NONVOLATILE_INTERFACE_CONFIG_OFF) begin
                    nonvolatile_interface_config_q <= shift_q;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= DS_IDLE;
            ph_q <= PH_DEV;
            read_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            base_q <= `ISP_RD_ADDR_RST;
            ptr_q <= `ISP_RD_ADDR_RST;
            sda_oe_q <= 1'b0;
        end else if (wdt_fire_q || spi_q || stop_det) begin
            st_q <= DS_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            // Also a repeated start
            st_q <= DS_RX;
            ph_q <= PH_DEV;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                DS_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], bus_if.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        st_q <= DS_ACK;
                        sda_oe_q <= 1'b1;
                        if (ph_q == PH_DEV) begin
                            // Only seven-bit match
                            if (shift_q[7:1] == {`ISP_DEV_ADDR_HI, addr_select_pin_in}) begin
                                read_q <= shift_q[0];
                                ptr_q <= base_q;
                            end else begin
                                st_q <= DS_IDLE;
                                sda_oe_q <= 1'b0;
                            end
                        end else if (ph_q == PH_REG) begin
                            base_q <= shift_q;
                            ptr_q <= shift_q;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                DS_ACK: begin
                    if (scl_fall) begin
                        if (read_q) begin
                            st_q <= DS_TX;
                            shift_q <= rd_now;
                            sda_oe_q <= ~rd_now[7];
                            ptr_q <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h1;
                        end else begin
                            st_q <= DS_RX;
                            sda_oe_q <= 1'b0;
                            ph_q <= (ph_q == PH_DEV) ? PH_REG : PH_DATA;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == `ISP_BYTE_BITS) begin
                            st_q <= DS_MACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            sda_oe_q <= ~shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                DS_MACK: begin
                    if (scl_rise && bus_if.sda) begin
                        st_q <= DS_IDLE;
                    end else if (scl_fall) begin
                        st_q <= DS_TX;
                        shift_q <= rd_now;
                        sda_oe_q <= ~rd_now[7];
                        ptr_q <= ptr_q + 8'h01;
                        bit_cnt_q <= 4'h1;
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : isp_dev

//--- isp_cfg.svh
/*
 Constants of the I2C register slave port and of its host end.
 Assumes a 100 MHz system clock shared by both ends.
*/
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define ISP_DEV_ADDR_HI 6'h34
`define ISP_BYTE_BITS 4'd8
`define ISP_NONVOLATILE_INTERFACE_CONFIG_OFF 8'h70
`define ISP_NONVOLATILE_INTERFACE_CONFIG_RST 8'h00
`define ISP_NV_SPI_EN_BIT 0
`define ISP_NV_WDT_SEL_BIT 1
`define ISP_NV_WDT_EN_BIT 2
`define ISP_RD_ADDR_RST 8'h00
`define ISP_MEM_TOP_BIT 7
`define ISP_CLK_NS 10
`define ISP_WDT_SHORT_MS 1
`define ISP_WDT_LONG_MS 50
`define ISP_GAP_NORM_US 2
`define ISP_GAP_SUSP_US 450
`define ISP_SCL_KHZ 1000
`define ISP_H_REG_ADDR 3'h0
`define ISP_H_WDATA 3'h1
`define ISP_H_RDCNT 3'h2
`define ISP_H_STATUS 3'h3
`define ISP_H_RDATA 3'h4
`define ISP_H_CFG 3'h5
`define ISP_H_CFG_ASEL_BIT 0
`define ISP_H_CFG_SUSP_BIT 1
`endif

//--- isp_pkg.sv
/*
 Types shared by both ends of the I2C register slave port.
 Assumes isp_cfg.svh is on the include path.
*/
package isp_pkg;
    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} isp_dev_st_t;
    typedef enum logic [1:0] {PH_DEV, PH_REG, PH_DATA} isp_phase_t;
    typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP, HS_GAP} isp_host_st_t;
endpackage : isp_pkg

//--- isp_if.sv
/*
 Two-wire bus joining host and device ends; resolves the open-drain wires.
 Assumes both ends only pull low and pull-ups hold released lines high.
*/
`timescale 1ns/10ps
interface isp_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Wired-AND with pull-up
    assign scl = ~host_scl_oe;
    assign sda = ~(host_sda_oe | dev_sda_oe);
    modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
                  output host_sda_out, output host_sda_oe);
endinterface : isp_if

//--- isp_host.sv
/*
 Host end: I2C master running register writes and burst reads for software.
 Assumes one device on the bus and no clock stretching.
*/
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_host #(
    parameter int QTR_CYC = 1000000 / (`ISP_SCL_KHZ * 4 * `ISP_CLK_NS),
    parameter int GAP_NORM_CYC = `ISP_GAP_NORM_US * 1000 / `ISP_CLK_NS,
    parameter int GAP_SUSP_CYC = `ISP_GAP_SUSP_US * 1000 / `ISP_CLK_NS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    isp_if.host bus_if,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out
);
    import isp_pkg::*;

    if (QTR_CYC < 1 || QTR_CYC >= 256 || GAP_NORM_CYC < 1 || GAP_SUSP_CYC >= 65536) begin : g_chk
        $error("isp_host: timing counts out of range");
    end

    isp_host_st_t st_q;
    logic [7:0] reg_addr_q, wdata_q, left_q, rdata_q, qcnt_q;
    logic [1:0] cfg_q, ph_q;
    logic [2:0] step_q;
    logic [3:0] bit_q;
    logic [8:0] tx_q, rx_q;
    logic [15:0] gap_q;
    logic op_rd_q, nack_q, scl_oe_q, sda_oe_q, tick, idle, go_wr, go_rd;

    // Byte and ack slot per step; host acks every read byte but the last
    function automatic logic [8:0] next_tx(input logic [2:0] s, input logic [7:0] n);
        logic [6:0] dev;
        dev = {`ISP_DEV_ADDR_HI, cfg_q[`ISP_H_CFG_ASEL_BIT]};
        if (s == 3'd0) begin
            return {dev, 1'b0, 1'b1};
        end else if (s == 3'd1) begin
            return {reg_addr_q, 1'b1};
        end else if (s == 3'd2) begin
            return op_rd_q ? {dev, 1'b1, 1'b1} : {wdata_q, 1'b1};
        end else begin
            return {8'hff, n == 8'h01};
        end
    endfunction : next_tx

    assign tick = (qcnt_q == 8'(QTR_CYC - 1));
    assign idle = (st_q == HS_IDLE);
    assign go_wr = wr_in && idle && (addr_in == `ISP_H_WDATA);
    assign go_rd = wr_in && idle && (addr_in == `ISP_H_RDCNT) && (wdata_in != 8'h00);
    assign bus_if.host_scl_out = 1'b0;
    assign bus_if.host_sda_out = 1'b0;
    assign bus_if.host_scl_oe = scl_oe_q;
    assign bus_if.host_sda_oe = sda_oe_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_addr_q <= 8'h00;
            wdata_q <= 8'h00;
            cfg_q <= 2'b00;
            rdata_out <= 8'h00;
        end else begin
            if (wr_in && idle) begin
                if (addr_in == `ISP_H_REG_ADDR) begin
                    reg_addr_q <= wdata_in;
                end else if (addr_in == `ISP_H_WDATA) begin
                    wdata_q <= wdata_in;
                end else if (addr_in == `ISP_H_CFG) begin
                    cfg_q <= wdata_in[1:0];
                end
            end
            if (!rd_in) begin
                rdata_out <= 8'h00;
            end else if (addr_in == `ISP_H_REG_ADDR) begin
                rdata_out <= reg_addr_q;
            end else if (addr_in == `ISP_H_WDATA) begin
                rdata_out <= wdata_q;
            end else if (addr_in == `ISP_H_RDCNT) begin
                rdata_out <= left_q;
            end else if (addr_in == `ISP_H_STATUS) begin
                rdata_out <= {6'h00, nack_q, ~idle};
            end else if (addr_in == `ISP_H_RDATA) begin
                rdata_out <= rdata_q;
            end else if (addr_in == `ISP_H_CFG) begin
                rdata_out <= {6'h00, cfg_q};
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            qcnt_q <= 8'h00;
        end else if (idle || tick) begin
            qcnt_q <= 8'h00;
        end else begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= HS_IDLE;
            ph_q <= 2'd0;
            step_q <= 3'd0;
            bit_q <= 4'h0;
            left_q <= 8'h00;
            tx_q <= 9'h000;
            rx_q <= 9'h000;
            rdata_q <= 8'h00;
            gap_q <= 16'h0000;
            op_rd_q <= 1'b0;
            nack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (idle) begin
            if (go_wr || go_rd) begin
                st_q <= HS_START;
                op_rd_q <= go_rd;
                left_q <= go_rd ? wdata_in : 8'h00;
                step_q <= 3'd0;
                ph_q <= 2'd0;
                nack_q <= 1'b0;
            end
        end else if (st_q == HS_GAP) begin
            // Idle time after every transfer, not only writes
            if (gap_q == 16'h0000) begin
                st_q <= HS_IDLE;
            end else begin
                gap_q <= gap_q - 16'h0001;
            end
        end else if (tick) begin
            ph_q <= ph_q + 2'd1;
            case (st_q)
                HS_START: begin
                    // Same shape serves as repeated start
                    if (ph_q == 2'd0) begin
                        sda_oe_q <= 1'b0;
                    end else if (ph_q == 2'd1) begin
                        scl_oe_q <= 1'b0;
                    end else if (ph_q == 2'd2) begin
                        sda_oe_q <= 1'b1;
                    end else begin
                        scl_oe_q <= 1'b1;
                        st_q <= HS_BYTE;
                        bit_q <= 4'h0;
                        tx_q <= next_tx(step_q, left_q);
                    end
                end
                HS_BYTE: begin
                    if (ph_q == 2'd0) begin
                        sda_oe_q <= ~tx_q[8];
                    end else if (ph_q == 2'd1) begin
                        scl_oe_q <= 1'b0;
                    end else if (ph_q == 2'd2) begin
                        rx_q <= {rx_q[7:0], bus_if.sda};
                    end else begin
                        scl_oe_q <= 1'b1;
                        tx_q <= {tx_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `ISP_BYTE_BITS) begin
                            bit_q <= 4'h0;
                            sda_oe_q <= 1'b0;
                            if (step_q < 3'd3 && rx_q[0]) begin
                                nack_q <= 1'b1;
                                st_q <= HS_STOP;
                            end else if (step_q == 3'd1 && op_rd_q) begin
                                step_q <= 3'd2;
                                st_q <= HS_START;
                            end else if (step_q == 3'd2 && !op_rd_q) begin
                                st_q <= HS_STOP;
                            end else if (step_q == 3'd3 && left_q == 8'h01) begin
                                rdata_q <= rx_q[8:1];
                                left_q <= 8'h00;
                                st_q <= HS_STOP;
                            end else begin
                                if (step_q == 3'd3) begin
                                    rdata_q <= rx_q[8:1];
                                    left_q <= left_q - 8'h01;
                                end else begin
                                    step_q <= step_q + 3'd1;
                                end
                                tx_q <= next_tx((step_q == 3'd3) ? step_q : step_q + 3'd1,
                                                (step_q == 3'd3) ? left_q - 8'h01 : left_q);
                            end
                        end
                    end
                end
                HS_STOP: begin
                    if (ph_q == 2'd0) begin
                        sda_oe_q <= 1'b1;
                    end else if (ph_q == 2'd1) begin
                        scl_oe_q <= 1'b0;
                    end else if (ph_q == 2'd2) begin
                        sda_oe_q <= 1'b0;
                    end else begin
                        st_q <= HS_GAP;
                        gap_q <= cfg_q[`ISP_H_CFG_SUSP_BIT] ? 16'(GAP_SUSP_CYC)
                                                            : 16'(GAP_NORM_CYC);
                    end
                end
                default: begin
                    st_q <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : isp_host

//--- isp_monitor.sv
/*
 Concurrent checks on the two-wire link between host and device ends.
 Assumes the resolved bus and all enables of the shared interface as inputs.
*/
`timescale 1ns/10ps
module isp_monitor (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_out,
    input wire logic host_scl_oe,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe
);
    logic [7:0] hold_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Bounds how long the device may keep SDA low
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_q <= 8'h00;
        end else begin
            hold_q <= dev_sda_oe ? hold_q + 8'h01 : 8'h00;
        end
    end
    sequence start_s;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $past(scl) && $rose(sda);
    endsequence
    open_drain_a: assert property (!dev_sda_out && !host_sda_out && !host_scl_out)
        else $error("open drain value driven high");
    ack_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device SDA moved while SCL high");
    no_contend_a: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
        else $error("host and device both drive SDA");
    dev_pull_a: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("device pulled SDA during SCL high");
    dev_release_a: assert property ($fell(dev_sda_oe) |-> !scl)
        else $error("device released SDA during SCL high");
    start_quiet_a: assert property (start_s |-> !dev_sda_oe [*3])
        else $error("device drives SDA at start");
    stop_idle_a: assert property (stop_s |=> !dev_sda_oe [*4])
        else $error("device drives SDA after stop");
    scl_low_a: assert property ($rose(host_scl_oe) |-> host_scl_oe [*4])
        else $error("SCL low phase too short");
    scl_high_a: assert property ($fell(host_scl_oe) |-> !host_scl_oe [*4])
        else $error("SCL high phase too short");
    hold_bound_a: assert property (hold_q < 8'd200)
        else $error("device holds SDA too long");
endmodule : isp_monitor

//--- tb_top.sv
/*
 Self-checking bench: host end drives device end over the shared bus.
 Assumes shortened SCL quarter, gap and watchdog parameters.
*/
`timescale 1ns/10ps
module tb_top;
    logic clk_in, nrst_in, asel_pin, cs_pin, wr_in, rd_in, rd_d;
    logic reg_wr, spi_mode, busy, wdt;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, wa, wd, last_rd, r, d, e;
    logic [8:0] ent;
    logic [8:0] rq[$];
    logic [15:0] wq[$];
    int miscompares, n_compared, cyc, i;
    isp_if bus_if();
    isp_dev #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(40)) isp_dev_inst(.clk_in(clk_in),
        .nrst_in(nrst_in), .bus_if(bus_if.dev), .addr_select_pin_in(asel_pin),
        .chip_select_pin_in(cs_pin), .reg_wr_out(reg_wr), .reg_wr_addr_out(wa),
        .reg_wr_data_out(wd), .spi_mode_out(spi_mode), .busy_out(busy), .wdt_reset_out(wdt));
    isp_host #(.QTR_CYC(4), .GAP_NORM_CYC(4), .GAP_SUSP_CYC(8)) isp_host_inst(.clk_in(clk_in),
        .nrst_in(nrst_in), .bus_if(bus_if.host), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
    isp_monitor isp_monitor_inst(.clk_in(clk_in), .nrst_in(nrst_in), .scl(bus_if.scl),
        .sda(bus_if.sda), .host_scl_out(bus_if.host_scl_out), .host_scl_oe(bus_if.host_scl_oe),
        .host_sda_out(bus_if.host_sda_out), .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_out(bus_if.dev_sda_out), .dev_sda_oe(bus_if.dev_sda_oe));
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    // Bit 8 of a note marks a status poll, kept rather than compared
    task rd(input logic [2:0] a, input logic [8:0] x);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        rq.push_back(x);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask : rd
    task idle;
        for (int k = 0; k < 3000; k++) begin
            rd(3'h3, 9'h100);
            repeat (2) @(posedge clk_in);
            if (last_rd[0] === 1'b0) break;
        end
        check("bus idle", {13'h0, wdt, busy, last_rd[0]}, 16'h0);
    endtask : idle
    task xfer(input logic [7:0] a, input logic [7:0] v, input logic [7:0] cfg);
        wr(3'h0, a);
        wr(3'h5, cfg);
        wr(3'h1, v);
        idle();
    endtask : xfer
    task fetch(input logic [7:0] a, input logic [7:0] n);
        wr(3'h0, a);
        wr(3'h2, n);
        idle();
    endtask : fetch
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            finish_test();
        end
        if (reg_wr === 1'b1) begin
            if (wq.size() == 0) check("unexpected write", {wa, wd}, 16'h0);
            else check("register write", {wa, wd}, wq.pop_front());
        end
        if (rd_d) begin
            last_rd = rdata_out;
            ent = rq.pop_front();
            if (!ent[8]) check("read data", {8'h0, rdata_out}, {8'h0, ent[7:0]});
        end
        rd_d <= rd_in;
    end
    initial begin
        {nrst_in, asel_pin, cs_pin, wr_in, rd_in, rd_d, addr_in, wdata_in} = '0;
        {cyc, miscompares, n_compared, last_rd} = '0;
        void'($urandom(44335));
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(3'h6, 9'h000);
        for (i = 0; i < 4; i++) begin
            asel_pin <= i[0];
            // Kept below 0x6f so the burst neighbour never hits the config register
            r = 8'($urandom_range(8'h6e));
            d = 8'($urandom);
            if (i[0] == i[1]) wq.push_back({r, d});
            xfer(r, d, {6'h0, 1'($urandom_range(1)), i[1]});
            rd(3'h3, {7'h0, 1'(i[0] != i[1]), 1'b0});
            if (i[0] == i[1]) begin
                fetch(r, 8'h01);
                rd(3'h4, {1'b0, d});
            end
            $display("address test %0d done", i);
        end
        e = 8'($urandom);
        wq.push_back({r + 8'h01, e});
        xfer(r + 8'h01, e, 8'h01);
        fetch(r, 8'h02);
        rd(3'h4, {1'b0, e});
        fetch(8'h70, 8'h01);
        rd(3'h4, 9'h000);
        fetch(r, 8'h01);
        rd(3'h4, {1'b0, d});
        $display("burst test done");
        check("i2c mode", {15'h0, spi_mode}, 16'h0);
        @(posedge clk_in);
        cs_pin <= 1'b1;
        xfer(r, d, 8'h01);
        rd(3'h3, 9'h002);
        check("spi mode", {15'h0, spi_mode}, 16'h1);
        check("pending writes", 16'(wq.size()), 16'h0);
        $display("mode test done");
        finish_test();
    end
endmodule : tb_top
